// >>> hdl/rsd_regs.vh
// Register map, field positions, reset values and timing counts.
// Assumes an 8-bit register port with byte offsets and a 50 MHz clock.
// Function
// - Packet 15.4: receive wait before delimiter search
// - FSK: same receive wait before sync search
// - Transmit wait in microseconds before transmit state
// - Extension adds four-microsecond steps to both waits
// - Sync pattern built from three byte registers
// - Sync match tolerates up to programmed mismatches
// - Compare programmed count of sync bits, max 24
// - Sync length zero disables sync detection
// - FSK streaming bypass bit skips delimiter detection
// - FSK gain-lock bit freezes gain after preamble
// - Preamble bypass searches only for sync pattern
// - Preamble qualifies on level good pairs of twelve
// - Format byte selects one of four formats
// - Channel word: 24 bits over three bytes
// - Delay-disable bit bypasses both start waits
`ifndef RSD_REGS_VH
`define RSD_REGS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define RSD_OFS_BUF_CFG      10'h107
`define RSD_OFS_RX_WAIT      10'h109
`define RSD_OFS_TX_WAIT      10'h10A
`define RSD_OFS_WAIT_EXT     10'h10B
`define RSD_OFS_SYNC_LOW     10'h10C
`define RSD_OFS_SYNC_MID     10'h10D
`define RSD_OFS_SYNC_HIGH    10'h10E
`define RSD_OFS_SYNC_SETUP   10'h10F
`define RSD_OFS_PRE_SETUP    10'h111
`define RSD_OFS_FORMAT       10'h13E
`define RSD_OFS_CHAN_LOW     10'h300
`define RSD_OFS_CHAN_MID     10'h301
`define RSD_OFS_CHAN_HIGH    10'h302

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RSD_RST_BUF_CFG      8'h00
`define RSD_RST_RX_WAIT      8'hC0
`define RSD_RST_TX_WAIT      8'hC0
`define RSD_RST_WAIT_EXT     8'h00
`define RSD_RST_SYNC_LOW     8'h31
`define RSD_RST_SYNC_MID     8'h7A
`define RSD_RST_SYNC_HIGH    8'hAA
`define RSD_RST_SYNC_SETUP   8'h18
`define RSD_RST_PRE_SETUP    8'h0B
`define RSD_RST_FORMAT       8'h00
`define RSD_RST_CHAN_LOW     8'h80
`define RSD_RST_CHAN_MID     8'hA9
`define RSD_RST_CHAN_HIGH    8'h03

// ----------------------------------------
// Fields
// ----------------------------------------
`define RSD_BUF_DLY_OFF_BIT  7
`define RSD_SYNC_TOL_HI      6
`define RSD_SYNC_TOL_LO      5
`define RSD_SYNC_LEN_HI      4
`define RSD_SYNC_LEN_LO      0
`define RSD_SYNC_LEN_MAX     5'h18
`define RSD_PRE_SKIP_SYNC    6
`define RSD_PRE_AGC_LOCK     5
`define RSD_PRE_SKIP_PRE     4
`define RSD_PRE_LVL_HI       3
`define RSD_PRE_LVL_LO       0
`define RSD_PRE_PAIRS        4'hC

// ----------------------------------------
// Formats
// ----------------------------------------
`define RSD_FMT_PKT154       8'h00
`define RSD_FMT_STR154       8'h02
`define RSD_FMT_FSK_STR      8'h03
`define RSD_FMT_FSK_PKT      8'h04

// ----------------------------------------
// Timing
// ----------------------------------------
`define RSD_CLK_KHZ          50000
`define RSD_BASE_STEP_US     1
`define RSD_EXT_STEP_US      4

`endif

// >>> hdl/rsd_start_timer.v
// Start wait counter for receive and transmit commands.
// Assumes a one-cycle start pulse; a new start restarts the count.
`timescale 1ns/1ns
`include "rsd_regs.vh"
module rsd_start_timer #(
  parameter CNT_W = 17
) (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire       start,
  input  wire [7:0] base_us,
  input  wire [7:0] ext_steps,
  input  wire       bypass,
  output wire       done,
  output wire       busy
);
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam integer CYC_US_I  = (`RSD_CLK_KHZ / 1000) * `RSD_BASE_STEP_US;
  localparam integer CYC_EXT_I = (`RSD_CLK_KHZ / 1000) * `RSD_EXT_STEP_US;
  localparam [CNT_W-1:0] CYC_US  = CYC_US_I[CNT_W-1:0];
  localparam [CNT_W-1:0] CYC_EXT = CYC_EXT_I[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE     = {{(CNT_W-1){1'b0}}, 1'b1};

  reg  [CNT_W-1:0] cnt_reg;
  reg              busy_reg;
  reg              done_reg;
  wire [CNT_W-1:0] base_w;
  wire [CNT_W-1:0] ext_w;
  wire [CNT_W-1:0] load;

  assign base_w = {{(CNT_W-8){1'b0}}, base_us};
  assign ext_w  = {{(CNT_W-8){1'b0}}, ext_steps};
  assign load   = base_w * CYC_US + ext_w * CYC_EXT;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= {CNT_W{1'b0}};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (start) begin
      // Done rises max(load,1) edges after the start edge, or one edge when bypassed
      if (bypass || (load == {CNT_W{1'b0}})) begin
        cnt_reg <= {CNT_W{1'b0}};
      end else begin
        cnt_reg <= load - ONE;
      end
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (busy_reg) begin
      if (cnt_reg == {CNT_W{1'b0}}) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end else begin
        cnt_reg  <= cnt_reg - ONE;
        done_reg <= 1'b0;
      end
    end else begin
      done_reg <= 1'b0;
    end
  end

  assign done = done_reg;
  assign busy = busy_reg;
endmodule

// >>> hdl/rsd_sync_match.v
// Serial sync pattern correlator with bit-error tolerance.
// Assumes bits arrive newest last; clears its history when disabled.
`timescale 1ns/1ns
`include "rsd_regs.vh"
module rsd_sync_match #(
  parameter PAT_W = 24
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire             enable,
  input  wire             bit_in,
  input  wire             bit_valid,
  input  wire [PAT_W-1:0] pattern,
  input  wire [4:0]       len,
  input  wire [1:0]       tol,
  output wire             match
);
  reg  [PAT_W-1:0] shift_reg;
  reg  [4:0]       seen_reg;
  reg              match_reg;
  reg  [PAT_W-1:0] shift_next;
  reg  [PAT_W-1:0] mask;
  reg  [4:0]       errs;
  reg  [4:0]       len_eff;
  integer          i;

  // ----------------------------------------
  // Compare
  // ----------------------------------------
  always @* begin
    shift_next = {shift_reg[PAT_W-2:0], bit_in};
    // Reserved lengths above the pattern width act as full length
    len_eff = (len > `RSD_SYNC_LEN_MAX) ? `RSD_SYNC_LEN_MAX : len;
    errs = 5'h00;
    for (i = 0; i < PAT_W; i = i + 1) begin
      mask[i] = (i < len_eff);
      if (mask[i] && (shift_next[i] != pattern[i])) begin
        errs = errs + 5'h01;
      end
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= {PAT_W{1'b0}};
      seen_reg  <= 5'h00;
      match_reg <= 1'b0;
    end else if (!enable) begin
      shift_reg <= {PAT_W{1'b0}};
      seen_reg  <= 5'h00;
      match_reg <= 1'b0;
    end else if (bit_valid) begin
      shift_reg <= shift_next;
      if (seen_reg < `RSD_SYNC_LEN_MAX) begin
        seen_reg <= seen_reg + 5'h01;
      end
      // Length zero never matches: detection is off
      match_reg <= (len_eff != 5'h00) && ((seen_reg + 5'h01) >= len_eff) &&
                   (errs <= {3'h0, tol});
    end else begin
      match_reg <= 1'b0;
    end
  end

  assign match = match_reg;
endmodule

// >>> hdl/rsd_top.v
// Start wait, preamble and sync search, format and channel registers.
// Assumes the register port and command pulses are synchronous to clk_sys.
`timescale 1ns/1ns
`include "rsd_regs.vh"
module rsd_top #(
  parameter PAT_W = 24
) (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [9:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_we,
  input  wire        reg_re,
  output wire [7:0]  reg_rdata,
  input  wire        receive_command,
  input  wire        transmit_command,
  input  wire        rx_bit,
  input  wire        rx_bit_valid,
  output wire        start_wait_busy,
  output wire        rx_search_start,
  output wire        tx_state_enter,
  output wire        rssi_window_open,
  output wire        preamble_search,
  output wire        preamble_qualified,
  output wire        sync_search,
  output wire        sync_found,
  output wire        frame_locked,
  output wire        agc_gain_locked,
  output wire        transmit_active,
  output wire [7:0]  format_selector,
  output wire [23:0] sync_pattern,
  output wire [23:0] channel_word
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_PRE  = 3'h2;
  localparam [2:0] ST_SYNC = 3'h3;
  localparam [2:0] ST_LOCK = 3'h4;
  localparam [2:0] ST_TX   = 3'h5;

  // ----------------------------------------
  // Format decode
  // ----------------------------------------
  function is_fsk;
    input [7:0] fmt;
    begin
      is_fsk = (fmt == `RSD_FMT_FSK_STR) || (fmt == `RSD_FMT_FSK_PKT);
    end
  endfunction

  function is_154;
    input [7:0] fmt;
    begin
      is_154 = (fmt == `RSD_FMT_PKT154) || (fmt == `RSD_FMT_STR154);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg        dly_off_reg;
  reg [7:0]  rx_wait_reg;
  reg [7:0]  tx_wait_reg;
  reg [7:0]  wait_ext_reg;
  reg [7:0]  sync_low_reg;
  reg [7:0]  sync_mid_reg;
  reg [7:0]  sync_high_reg;
  reg [6:0]  sync_setup_reg;
  reg [6:0]  pre_setup_reg;
  reg [7:0]  format_reg;
  reg [7:0]  chan_low_reg;
  reg [7:0]  chan_mid_reg;
  reg [7:0]  chan_high_reg;
  reg [7:0]  rdata_reg;
  reg [7:0]  rdata_next;
  // Full-width reset images, sliced to the stored bits
  localparam [7:0] RST_BUF  = `RSD_RST_BUF_CFG;
  localparam [7:0] RST_SYNC = `RSD_RST_SYNC_SETUP;
  localparam [7:0] RST_PRE  = `RSD_RST_PRE_SETUP;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dly_off_reg    <= RST_BUF[`RSD_BUF_DLY_OFF_BIT];
      rx_wait_reg    <= `RSD_RST_RX_WAIT;
      tx_wait_reg    <= `RSD_RST_TX_WAIT;
      wait_ext_reg   <= `RSD_RST_WAIT_EXT;
      sync_low_reg   <= `RSD_RST_SYNC_LOW;
      sync_mid_reg   <= `RSD_RST_SYNC_MID;
      sync_high_reg  <= `RSD_RST_SYNC_HIGH;
      sync_setup_reg <= RST_SYNC[6:0];
      pre_setup_reg  <= RST_PRE[6:0];
      format_reg     <= `RSD_RST_FORMAT;
      chan_low_reg   <= `RSD_RST_CHAN_LOW;
      chan_mid_reg   <= `RSD_RST_CHAN_MID;
      chan_high_reg  <= `RSD_RST_CHAN_HIGH;
    end else if (reg_we) begin
      case (reg_addr)
        `RSD_OFS_BUF_CFG:    dly_off_reg    <= reg_wdata[`RSD_BUF_DLY_OFF_BIT];
        `RSD_OFS_RX_WAIT:    rx_wait_reg    <= reg_wdata;
        `RSD_OFS_TX_WAIT:    tx_wait_reg    <= reg_wdata;
        `RSD_OFS_WAIT_EXT:   wait_ext_reg   <= reg_wdata;
        `RSD_OFS_SYNC_LOW:   sync_low_reg   <= reg_wdata;
        `RSD_OFS_SYNC_MID:   sync_mid_reg   <= reg_wdata;
        `RSD_OFS_SYNC_HIGH:  sync_high_reg  <= reg_wdata;
        `RSD_OFS_SYNC_SETUP: sync_setup_reg <= reg_wdata[6:0];
        `RSD_OFS_PRE_SETUP:  pre_setup_reg  <= reg_wdata[6:0];
        `RSD_OFS_FORMAT:     format_reg     <= reg_wdata;
        `RSD_OFS_CHAN_LOW:   chan_low_reg   <= reg_wdata;
        `RSD_OFS_CHAN_MID:   chan_mid_reg   <= reg_wdata;
        `RSD_OFS_CHAN_HIGH:  chan_high_reg  <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Reserved bits read as zero
  always @* begin
    case (reg_addr)
      `RSD_OFS_BUF_CFG:    rdata_next = {dly_off_reg, 7'h00};
      `RSD_OFS_RX_WAIT:    rdata_next = rx_wait_reg;
      `RSD_OFS_TX_WAIT:    rdata_next = tx_wait_reg;
      `RSD_OFS_WAIT_EXT:   rdata_next = wait_ext_reg;
      `RSD_OFS_SYNC_LOW:   rdata_next = sync_low_reg;
      `RSD_OFS_SYNC_MID:   rdata_next = sync_mid_reg;
      `RSD_OFS_SYNC_HIGH:  rdata_next = sync_high_reg;
      `RSD_OFS_SYNC_SETUP: rdata_next = {1'b0, sync_setup_reg};
      `RSD_OFS_PRE_SETUP:  rdata_next = {1'b0, pre_setup_reg};
      `RSD_OFS_FORMAT:     rdata_next = format_reg;
      `RSD_OFS_CHAN_LOW:   rdata_next = chan_low_reg;
      `RSD_OFS_CHAN_MID:   rdata_next = chan_mid_reg;
      `RSD_OFS_CHAN_HIGH:  rdata_next = chan_high_reg;
      default:             rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (reg_re) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  wire [1:0] sync_tol  = sync_setup_reg[`RSD_SYNC_TOL_HI:`RSD_SYNC_TOL_LO];
  wire [4:0] sync_len  = sync_setup_reg[`RSD_SYNC_LEN_HI:`RSD_SYNC_LEN_LO];
  wire       skip_sync = pre_setup_reg[`RSD_PRE_SKIP_SYNC];
  wire       agc_lock  = pre_setup_reg[`RSD_PRE_AGC_LOCK];
  wire       skip_pre  = pre_setup_reg[`RSD_PRE_SKIP_PRE];
  wire [3:0] pre_level = pre_setup_reg[`RSD_PRE_LVL_HI:`RSD_PRE_LVL_LO];
  wire       fmt_fsk   = is_fsk(format_reg);
  wire       fmt_154   = is_154(format_reg);

  // ----------------------------------------
  // Start wait
  // ----------------------------------------
  reg        dir_tx_reg;
  wire       cmd_any = receive_command || transmit_command;
  // Transmit wins when both commands arrive together
  wire       cmd_tx  = transmit_command;
  wire       wait_done;
  wire [7:0] base_sel = cmd_tx ? tx_wait_reg : rx_wait_reg;

  rsd_start_timer #(
    .CNT_W     (17)
  ) u_timer (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .start     (cmd_any),
    .base_us   (base_sel),
    .ext_steps (wait_ext_reg),
    .bypass    (dly_off_reg),
    .done      (wait_done),
    .busy      (start_wait_busy)
  );

  // ----------------------------------------
  // Search sequence
  // ----------------------------------------
  reg  [2:0] st_reg;
  reg  [2:0] st_next;
  reg        rssi_reg;
  reg        agc_reg;
  wire       pre_ok;
  wire       sync_hit;
  wire       wait_rx = wait_done && !dir_tx_reg && (st_reg == ST_WAIT);
  wire       wait_tx = wait_done && dir_tx_reg && (st_reg == ST_WAIT);
  // Preamble stage only exists in the FSK formats
  wire       need_pre = fmt_fsk && !skip_pre;
  wire       bypass_sync = (format_reg == `RSD_FMT_FSK_STR) && skip_sync;

  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: st_next = ST_IDLE;
      ST_WAIT: begin
        if (wait_tx) begin
          st_next = ST_TX;
        end else if (wait_rx) begin
          if (bypass_sync || (sync_len == 5'h00)) begin
            st_next = ST_LOCK;
          end else if (need_pre) begin
            st_next = ST_PRE;
          end else begin
            st_next = ST_SYNC;
          end
        end
      end
      ST_PRE: begin
        if (pre_ok) begin
          st_next = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (sync_hit) begin
          st_next = ST_LOCK;
        end
      end
      ST_LOCK: st_next = ST_LOCK;
      ST_TX:   st_next = ST_TX;
      default: st_next = ST_IDLE;
    endcase
    // A new command always restarts the sequence
    if (cmd_any) begin
      st_next = ST_WAIT;
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg     <= ST_IDLE;
      dir_tx_reg <= 1'b0;
      rssi_reg   <= 1'b0;
      agc_reg    <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (cmd_any) begin
        dir_tx_reg <= cmd_tx;
        rssi_reg   <= 1'b0;
        agc_reg    <= 1'b0;
      end else begin
        if (wait_rx && fmt_154) begin
          rssi_reg <= 1'b1;
        end
        if ((st_reg == ST_PRE) && pre_ok && agc_lock && fmt_fsk) begin
          agc_reg <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Preamble qualifier
  // ----------------------------------------
  reg        half_reg;
  reg        first_reg;
  reg [11:0] pair_hist_reg;
  reg [3:0]  pairs_reg;
  reg [3:0]  good_cnt;
  reg [3:0]  lvl_eff;
  integer    k;

  always @* begin
    good_cnt = 4'h0;
    for (k = 0; k < 12; k = k + 1) begin
      good_cnt = good_cnt + {3'h0, pair_hist_reg[k]};
    end
    // Reserved levels above twelve demand a clean preamble
    lvl_eff = (pre_level > `RSD_PRE_PAIRS) ? `RSD_PRE_PAIRS : pre_level;
  end

  // A pair is good when its two bits differ, as in 0101 patterns
  assign pre_ok = (lvl_eff == 4'h0) ||
                  ((pairs_reg == `RSD_PRE_PAIRS) && (good_cnt >= lvl_eff));

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      half_reg      <= 1'b0;
      first_reg     <= 1'b0;
      pair_hist_reg <= 12'h000;
      pairs_reg     <= 4'h0;
    end else if (st_reg != ST_PRE) begin
      half_reg      <= 1'b0;
      pair_hist_reg <= 12'h000;
      pairs_reg     <= 4'h0;
    end else if (rx_bit_valid) begin
      half_reg <= !half_reg;
      if (!half_reg) begin
        first_reg <= rx_bit;
      end else begin
        pair_hist_reg <= {pair_hist_reg[10:0], first_reg ^ rx_bit};
        if (pairs_reg != `RSD_PRE_PAIRS) begin
          pairs_reg <= pairs_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Sync correlator
  // ----------------------------------------
  rsd_sync_match #(
    .PAT_W     (PAT_W)
  ) u_sync (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .enable    ((st_reg == ST_SYNC) && !cmd_any),
    .bit_in    (rx_bit),
    .bit_valid (rx_bit_valid),
    .pattern   (sync_pattern),
    .len       (sync_len),
    .tol       (sync_tol),
    .match     (sync_hit)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata          = rdata_reg;
  assign rx_search_start    = wait_rx;
  assign tx_state_enter     = wait_tx;
  assign rssi_window_open   = rssi_reg;
  assign preamble_search    = (st_reg == ST_PRE);
  assign preamble_qualified = (st_reg == ST_PRE) && pre_ok;
  assign sync_search        = (st_reg == ST_SYNC);
  assign sync_found         = (st_reg == ST_SYNC) && sync_hit;
  assign frame_locked       = (st_reg == ST_LOCK);
  assign agc_gain_locked    = agc_reg;
  assign transmit_active    = (st_reg == ST_TX);
  assign format_selector    = format_reg;
  assign sync_pattern       = {sync_high_reg, sync_mid_reg, sync_low_reg};
  assign channel_word       = {chan_high_reg, chan_mid_reg, chan_low_reg};
endmodule

// >>> sim/rsd_top_properties.sv
// Checker for the start wait and receive search outputs.
// Assumes the single clk_sys domain and asynchronous active-low rstn.
`timescale 1ns/1ns
module rsd_top_properties (
  input logic       clk_sys,
  input logic       rstn,
  input logic       receive_command,
  input logic       transmit_command,
  input logic       rx_bit_valid,
  input logic       start_wait_busy,
  input logic       rx_search_start,
  input logic       tx_state_enter,
  input logic       rssi_window_open,
  input logic       preamble_search,
  input logic       preamble_qualified,
  input logic       sync_search,
  input logic       sync_found,
  input logic       frame_locked,
  input logic       agc_gain_locked,
  input logic       transmit_active,
  input logic [7:0] format_selector
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire cmd = receive_command || transmit_command;
  wire fsk = format_selector == 8'h03 || format_selector == 8'h04;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_busy_cause;
    $rose(start_wait_busy) |-> $past(cmd);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
  property p_tx_active;
    tx_state_enter |-> ##[0:1] transmit_active;
  endproperty
  a_tx_active: assert property (p_tx_active) else $error("no transmit state");
  property p_cmd_clear;
    cmd |=> !rssi_window_open && !agc_gain_locked;
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("flags kept over command");
  property p_rssi_cause;
    $rose(rssi_window_open) |->
      $past(rx_search_start) && (format_selector == 8'h00 || format_selector == 8'h02);
  endproperty
  a_rssi_cause: assert property (p_rssi_cause) else $error("bad window start");
  property p_agc_fmt;
    $rose(agc_gain_locked) |-> fsk;
  endproperty
  a_agc_fmt: assert property (p_agc_fmt) else $error("gain lock outside fsk");
  property p_qual_stage;
    preamble_qualified |-> preamble_search ##1 sync_search;
  endproperty
  a_qual_stage: assert property (p_qual_stage) else $error("bad qualify exit");
  property p_sync_cause;
    sync_found |-> $past(rx_bit_valid) ##[0:1] frame_locked;
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("bad sync match");
  property p_pre_fmt;
    preamble_search |-> fsk;
  endproperty
  a_pre_fmt: assert property (p_pre_fmt) else $error("preamble stage outside fsk");
  property p_lock_idle;
    frame_locked && !cmd |=> frame_locked && !sync_search && !preamble_search;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("search after lock");
  c_sync: cover property (sync_found);
  c_qual: cover property (preamble_qualified);
  c_tx: cover property (tx_state_enter);
  c_lock: cover property (frame_locked && !sync_found);
endmodule
bind rsd_top rsd_top_properties u_props (
  .clk_sys(clk_sys), .rstn(rstn), .receive_command(receive_command),
  .transmit_command(transmit_command), .rx_bit_valid(rx_bit_valid),
  .start_wait_busy(start_wait_busy), .rx_search_start(rx_search_start),
  .tx_state_enter(tx_state_enter), .rssi_window_open(rssi_window_open),
  .preamble_search(preamble_search), .preamble_qualified(preamble_qualified),
  .sync_search(sync_search), .sync_found(sync_found), .frame_locked(frame_locked),
  .agc_gain_locked(agc_gain_locked), .transmit_active(transmit_active),
  .format_selector(format_selector));

// >>> sim/rsd_host_model.sv
// Host controller model driving the register port.
// Assumes one strobe per access, released data shows the inverse.
`timescale 1ns/1ns
module rsd_host_model (
  input  logic       clk_sys,
  output logic [9:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_we,
  output logic       reg_re,
  input  logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask
  // Data read one cycle after the strobe edge
  task rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// >>> sim/rsd_top_tb_top.sv
// Testbench for the start wait, search and register block.
// Assumes a 50 MHz clk_sys; host model owns the register port.
`timescale 1ns/1ns
module rsd_top_tb_top;
  logic clk_sys = 0, rstn = 0, rx_cmd = 0, tx_cmd = 0, rx_bit = 0, rx_vld = 0;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, fmt, d;
  logic reg_we, reg_re, busy, rx_go, tx_go, rssi, pre_s, pre_q, syn_s, syn_f, lock, agc, tx_act;
  logic [23:0] sync_pattern, channel_word;
  logic seen_s, seen_q;
  int err_count = 0, compares = 0, i;
  logic [9:0] ra [13] = '{10'h107, 10'h109, 10'h10A, 10'h10B, 10'h10C, 10'h10D, 10'h10E,
                          10'h10F, 10'h111, 10'h13E, 10'h300, 10'h301, 10'h302};
  logic [7:0] rv [13] = '{8'h00, 8'hC0, 8'hC0, 8'h00, 8'h31, 8'h7A, 8'hAA,
                          8'h18, 8'h0B, 8'h00, 8'h80, 8'hA9, 8'h03};
  logic [7:0] fm [4] = '{8'h00, 8'h02, 8'h03, 8'h04};
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (syn_f === 1'b1) seen_s = 1;
    if (pre_q === 1'b1) seen_q = 1;
  end
  rsd_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  rsd_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .receive_command(rx_cmd),
    .transmit_command(tx_cmd), .rx_bit(rx_bit), .rx_bit_valid(rx_vld),
    .start_wait_busy(busy), .rx_search_start(rx_go), .tx_state_enter(tx_go),
    .rssi_window_open(rssi), .preamble_search(pre_s), .preamble_qualified(pre_q),
    .sync_search(syn_s), .sync_found(syn_f), .frame_locked(lock), .agc_gain_locked(agc),
    .transmit_active(tx_act), .format_selector(fmt), .sync_pattern(sync_pattern),
    .channel_word(channel_word));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task conclude;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // Edges from command edge to end pulse
  task cmdw(input logic tx, input int l);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (tx) tx_cmd <= 1; else rx_cmd <= 1;
    @(posedge clk_sys);
    tx_cmd <= 0;
    rx_cmd <= 0;
    seen_s = 0;
    seen_q = 0;
    while (n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
      if (n == 1) chk("busy", l > 1, busy);
      if ((tx ? tx_go : rx_go) === 1'b1) break;
    end
    if (n >= 20000) begin
      $display("CHECK FAILED wait expected %0d seen timeout", l);
      err_count++;
      conclude;
    end
    chk("wait", l, n);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Newest bit last; idle bit line shows the inverse
  task bits(input logic [23:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      @(posedge clk_sys);
      rx_bit <= v[k];
      rx_vld <= 1;
      @(posedge clk_sys);
      rx_vld <= 0;
      rx_bit <= ~v[k];
    end
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1;
    chk("sync", 24'hAA7A31, sync_pattern);
    chk("chan", 24'h03A980, channel_word);
    for (i = 0; i < 13; i++) begin
      u_host.rd(ra[i], d);
      chk("reset", rv[i], d);
      u_host.wr(ra[i], 8'hA0 + i[7:0]);
      u_host.rd(ra[i], d);
      chk("rw", (8'hA0 + i[7:0]) & (i == 0 ? 8'h80 : (i == 7 || i == 8) ? 8'h7F : 8'hFF), d);
    end
    u_host.wr(10'h110, 8'hFF);
    u_host.rd(10'h110, d);
    chk("unmapped", 8'h00, d);
    chk("sync", 24'hA6A5A4, sync_pattern);
    chk("chan", 24'hACABAA, channel_word);
    for (i = 0; i < 4; i++) begin
      u_host.wr(10'h13E, fm[i]);
      chk("fmt", fm[i], fmt);
    end
    cmdw(0, 1);
    cmdw(1, 1);
    u_host.wr(10'h107, 8'h00);
    u_host.wr(10'h109, 8'h02);
    u_host.wr(10'h10B, 8'h01);
    cmdw(0, 300);
    u_host.wr(10'h10A, 8'h03);
    u_host.wr(10'h10B, 8'h00);
    cmdw(1, 150);
    chk("txact", 1, tx_act);
    u_host.wr(10'h109, 8'h01);
    u_host.wr(10'h13E, 8'h00);
    u_host.wr(10'h10F, 8'h38);
    cmdw(0, 50);
    chk("rssi", 1, rssi);
    bits(24'hA6A4A4, 24);
    chk("tol1", 1, seen_s & lock);
    u_host.wr(10'h10F, 8'h18);
    cmdw(0, 50);
    bits(24'hA6A4A4, 24);
    chk("tol0", 0, seen_s);
    bits(24'hA6A5A4, 24);
    chk("exact", 1, seen_s);
    u_host.wr(10'h10F, 8'h00);
    cmdw(0, 50);
    chk("len0", 2, {lock, syn_s});
    u_host.wr(10'h10F, 8'h18);
    u_host.wr(10'h13E, 8'h03);
    u_host.wr(10'h111, 8'h40);
    cmdw(0, 50);
    chk("skip", 2, {lock, rssi});
    u_host.wr(10'h13E, 8'h04);
    cmdw(0, 50);
    chk("nskip", 1, {lock, syn_s});
    u_host.wr(10'h111, 8'h2C);
    cmdw(0, 50);
    chk("pre", 1, pre_s);
    bits(24'hAAAAAA, 24);
    chk("qual", 7, {seen_q, agc, syn_s});
    cmdw(0, 50);
    bits(24'hAAAAAB, 24);
    chk("noqual", 0, seen_q);
    u_host.wr(10'h111, 8'h10);
    cmdw(0, 50);
    chk("bypass", 1, {agc, pre_s, syn_s});
    conclude;
  end
endmodule
